// File: adc_result_ram_pkg.sv
// constants shared by the result memory read-out block and its memory
// assumes a single system clock domain; nothing here is synthesised on its own
package adc_result_ram_pkg;

  localparam int unsigned result_memory_data_width     = 9;
  localparam int unsigned averaged_memory_address_width = 9;
  localparam int unsigned result_memory_depth          = 512;
  localparam int unsigned conversion_result_width      = 12;
  localparam int unsigned result_index_width           = 8;

  // a 12-bit result splits into a 9-bit low word and a 3-bit high word
  localparam int unsigned low_word_lsb                 = 0;
  localparam int unsigned low_word_width               = 9;
  localparam int unsigned high_word_lsb                = 9;
  localparam int unsigned high_word_width              = 3;
  localparam logic [0:0]  low_word_address_offset      = 1'h0;
  localparam logic [0:0]  high_word_address_offset     = 1'h1;

  localparam logic [8:0]  read_data_reset_value        = 9'h000;
  localparam int unsigned result_memory_count          = 2;
  localparam int unsigned raw_memory_select            = 0;
  localparam int unsigned averaged_memory_select       = 1;

  typedef enum logic [1:0] {
    writer_idle       = 2'b00,
    writer_low_word   = 2'b01,
    writer_high_word  = 2'b10
  } writer_state_type;

endpackage : adc_result_ram_pkg

// File: result_memory.sv
// 512x9 dual-port result memory: port a reads, port b writes
// assumes both ports run on the one system clock; read data is registered
module result_memory
  import adc_result_ram_pkg::*;
(
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  // port a, read
  input  wire logic                                     port_a_read_enable,
  input  wire logic [averaged_memory_address_width-1:0] port_a_address,
  output logic      [result_memory_data_width-1:0]      port_a_data,
  // port b, write
  input  wire logic                                     port_b_write_enable,
  input  wire logic [averaged_memory_address_width-1:0] port_b_address,
  input  wire logic [result_memory_data_width-1:0]      port_b_data
);

  logic [result_memory_data_width-1:0] storage [result_memory_depth];

  always_ff @(posedge clock) begin
    if (port_b_write_enable) begin
      storage[port_b_address] <= port_b_data;
    end
  end

  // read data appears one edge after enable and address are sampled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_a_data <= read_data_reset_value;
    end else if (port_a_read_enable) begin
      port_a_data <= storage[port_a_address];
    end
  end

endmodule : result_memory

// File: adc_result_ram_user_read.sv
// raw and averaged result memories with their writers and shared port-a read paths
// assumes the sequencer, evaluators and init/config logic run on the same clock
//
// Contract
// [R1] sequencer writes each slot's raw unfiltered result into the raw memory
// [R2] raw results are kept per slot, each slot at its own locations
// [R3] each processed slot overwrites that slot's raw locations
// [R4] raw result: bits 8..0 at lower address, bits 11..9 at next address
// [R5] user drives a 9-bit raw read address; tie constant when unused
// [R6] user raises raw read enable, takes port-a data; hold low when unused
// [R7] user first raises raw read enable only while raw port-a busy is low
// [R8] raw port-a busy is high while init/config or evaluator uses port a
// [R9] raw write busy is high while the sequencer writes port b
// [R10] raw memory port-a output is the user read data
// [R11] averaging evaluator stores filtered results per channel
// [R12] each processed channel overwrites that channel's averaged locations
// [R13] averaged result: bits 8..0 first location, bits 11..9 next location
// [R14] user drives a 9-bit averaged read address; tie constant when unused
// [R15] averaged read enable low when unused; first raise only when busy low
// [R16] averaged port-a busy is high while init/config or threshold logic uses port a
// [R17] averaged write busy is high while the averaging evaluator writes port b
// [R18] averaged memory port-a output is the user read data
// [R19] read data appears one clock after enable and address are sampled
module adc_result_ram_user_read
  import adc_result_ram_pkg::*;
(
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  // sample sequencer results, one per processed slot
  input  wire logic                                     sample_sequencer_valid,
  input  wire logic [result_index_width-1:0]            sample_sequencer_slot,
  input  wire logic [conversion_result_width-1:0]       sample_sequencer_result,
  // averaging evaluator results, one per processed channel
  input  wire logic                                     averaging_evaluator_valid,
  input  wire logic [result_index_width-1:0]            averaging_evaluator_channel,
  input  wire logic [conversion_result_width-1:0]       averaging_evaluator_result,
  // internal port-a users of the raw memory
  input  wire logic                                     raw_init_config_read,
  input  wire logic [averaged_memory_address_width-1:0] raw_init_config_address,
  input  wire logic                                     raw_evaluator_read,
  input  wire logic [averaged_memory_address_width-1:0] raw_evaluator_address,
  // internal port-a users of the averaged memory
  input  wire logic                                     averaged_init_config_read,
  input  wire logic [averaged_memory_address_width-1:0] averaged_init_config_address,
  input  wire logic                                     threshold_evaluator_read,
  input  wire logic [averaged_memory_address_width-1:0] threshold_evaluator_address,
  // user read path, raw memory
  input  wire logic                                     raw_result_read_enable,
  input  wire logic [averaged_memory_address_width-1:0] raw_result_read_address,
  output logic      [result_memory_data_width-1:0]      raw_result_port_a_data,
  output logic                                          raw_result_port_a_busy,
  output logic                                          raw_result_write_busy,
  // user read path, averaged memory
  input  wire logic                                     averaged_result_read_enable,
  input  wire logic [averaged_memory_address_width-1:0] averaged_result_read_address,
  output logic      [result_memory_data_width-1:0]      averaged_result_port_a_data,
  output logic                                          averaged_result_port_a_busy,
  output logic                                          averaged_result_write_busy
);

  localparam int unsigned aw = averaged_memory_address_width;
  localparam int unsigned dw = result_memory_data_width;
  localparam int unsigned rw = conversion_result_width;
  localparam int unsigned iw = result_index_width;

  // per-memory views: index 0 raw results, index 1 averaged results
  logic [result_memory_count-1:0]         producer_valid;
  logic [iw-1:0]                          producer_index   [result_memory_count];
  logic [rw-1:0]                          producer_result  [result_memory_count];
  logic [result_memory_count-1:0]         init_read;
  logic [aw-1:0]                          init_address     [result_memory_count];
  logic [result_memory_count-1:0]         engine_read;
  logic [aw-1:0]                          engine_address   [result_memory_count];
  logic [result_memory_count-1:0]         user_read;
  logic [aw-1:0]                          user_address     [result_memory_count];
  logic [dw-1:0]                          port_a_data      [result_memory_count];
  logic [result_memory_count-1:0]         port_a_taken;
  logic [result_memory_count-1:0]         write_busy;

  assign producer_valid[raw_memory_select]       = sample_sequencer_valid;
  assign producer_index[raw_memory_select]       = sample_sequencer_slot;
  assign producer_result[raw_memory_select]      = sample_sequencer_result;
  assign producer_valid[averaged_memory_select]  = averaging_evaluator_valid;
  assign producer_index[averaged_memory_select]  = averaging_evaluator_channel;
  assign producer_result[averaged_memory_select] = averaging_evaluator_result;

  assign init_read[raw_memory_select]           = raw_init_config_read;
  assign init_address[raw_memory_select]        = raw_init_config_address;
  assign engine_read[raw_memory_select]         = raw_evaluator_read;
  assign engine_address[raw_memory_select]      = raw_evaluator_address;
  assign init_read[averaged_memory_select]      = averaged_init_config_read;
  assign init_address[averaged_memory_select]   = averaged_init_config_address;
  assign engine_read[averaged_memory_select]    = threshold_evaluator_read;
  assign engine_address[averaged_memory_select] = threshold_evaluator_address;

  assign user_read[raw_memory_select]         = raw_result_read_enable;       // R6
  assign user_address[raw_memory_select]      = raw_result_read_address;      // R5
  assign user_read[averaged_memory_select]    = averaged_result_read_enable;
  assign user_address[averaged_memory_select] = averaged_result_read_address; // R14

  assign raw_result_port_a_data      = port_a_data[raw_memory_select];        // R10
  assign averaged_result_port_a_data = port_a_data[averaged_memory_select];   // R18
  assign raw_result_port_a_busy      = port_a_taken[raw_memory_select];
  assign averaged_result_port_a_busy = port_a_taken[averaged_memory_select];
  assign raw_result_write_busy       = write_busy[raw_memory_select];
  assign averaged_result_write_busy  = write_busy[averaged_memory_select];

  for (genvar m = 0; m < result_memory_count; m++) begin : g_memory

    writer_state_type next_state;
    writer_state_type state;
    logic [iw-1:0]    held_index;
    logic [rw-1:0]    held_result;
    logic [aw-1:0]    taken_address;
    logic             port_b_write_enable;
    logic [aw-1:0]    port_b_address;
    logic [dw-1:0]    port_b_data;
    logic             port_a_read_enable;
    logic [aw-1:0]    port_a_address;

    // two-word write sequence; new results are ignored while busy
    always_comb begin
      next_state = state;
      unique case (state)
        writer_idle: begin
          if (producer_valid[m]) begin
            next_state = writer_low_word;
          end
        end
        writer_low_word: begin
          next_state = writer_high_word;
        end
        writer_high_word: begin
          next_state = writer_idle;
        end
        default: begin
          next_state = writer_idle;
        end
      endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        state <= writer_idle;
      end else begin
        state <= next_state;
      end
    end

    // capture the result of the slot or channel just processed
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        held_index  <= '0;
        held_result <= '0;
      end else if (state == writer_idle && producer_valid[m]) begin
        held_index  <= producer_index[m];  // R2 R11
        held_result <= producer_result[m]; // R1 R11
      end
    end

    // busy from the first word written through the last
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        write_busy[m] <= 1'b0;
      end else begin
        write_busy[m] <= (next_state != writer_idle); // R9 R17
      end
    end

    // each index owns two adjacent words, overwritten on every pass
    assign port_b_write_enable = (state != writer_idle);                      // R3 R12
    assign port_b_address = (state == writer_high_word)
                          ? {held_index, high_word_address_offset}
                          : {held_index, low_word_address_offset};            // R4 R13
    assign port_b_data    = (state == writer_high_word)
                          ? dw'(held_result[high_word_lsb +: high_word_width])
                          : held_result[low_word_lsb +: low_word_width];      // R4 R13

    // internal users take port a for a cycle; init/config has priority
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        port_a_taken[m] <= 1'b0;
        taken_address   <= '0;
      end else begin
        port_a_taken[m] <= init_read[m] | engine_read[m]; // R8 R16
        taken_address   <= init_read[m] ? init_address[m] : engine_address[m];
      end
    end

    // a user read overlapping busy gets the internal user's word
    assign port_a_read_enable = port_a_taken[m] | user_read[m];
    assign port_a_address     = port_a_taken[m] ? taken_address : user_address[m]; // R7 R15

    result_memory u_result_memory (
      .clock               (clock),
      .rst_n               (rst_n),
      .port_a_read_enable  (port_a_read_enable),
      .port_a_address      (port_a_address),
      .port_a_data         (port_a_data[m]),      // R19
      .port_b_write_enable (port_b_write_enable),
      .port_b_address      (port_b_address),
      .port_b_data         (port_b_data)
    );

  end

endmodule : adc_result_ram_user_read

// File: adc_result_ram_user_read_sva.sv
// checker of busy, write span and read data timing of the read-out block
// bound to the top module; one clock domain, async active-low reset
module result_read_sva
  import adc_result_ram_pkg::*;
(
  // clock, reset and requests
  input wire logic clock, rst_n, sample_sequencer_valid, averaging_evaluator_valid,
  input wire logic raw_init_config_read, raw_evaluator_read, raw_result_read_enable,
  input wire logic averaged_init_config_read, threshold_evaluator_read, averaged_result_read_enable,
  // status and data
  input wire logic raw_result_port_a_busy, raw_result_write_busy,
  input wire logic averaged_result_port_a_busy, averaged_result_write_busy,
  input wire logic [result_memory_data_width-1:0] raw_result_port_a_data, averaged_result_port_a_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_raw_busy_set: assert property ((raw_init_config_read || raw_evaluator_read) |=> raw_result_port_a_busy)
    else $error("raw busy missing");
  chk_raw_busy_clear: assert property (!(raw_init_config_read || raw_evaluator_read) |=> !raw_result_port_a_busy)
    else $error("raw busy without cause");
  chk_avg_busy_set: assert property ((averaged_init_config_read || threshold_evaluator_read) |=> averaged_result_port_a_busy)
    else $error("averaged busy missing");
  chk_avg_busy_clear: assert property (!(averaged_init_config_read || threshold_evaluator_read) |=> !averaged_result_port_a_busy)
    else $error("averaged busy without cause");
  chk_raw_write_span: assert property (sample_sequencer_valid && !raw_result_write_busy |=> raw_result_write_busy[*2] ##1 !raw_result_write_busy)
    else $error("raw write busy span wrong");
  chk_avg_write_span: assert property (averaging_evaluator_valid && !averaged_result_write_busy |=> averaged_result_write_busy[*2] ##1 !averaged_result_write_busy)
    else $error("averaged write busy span wrong");
  chk_raw_write_cause: assert property ($rose(raw_result_write_busy) |-> $past(sample_sequencer_valid))
    else $error("raw write busy without result");
  chk_raw_data_cause: assert property ($changed(raw_result_port_a_data) |-> $past(raw_result_read_enable) || $past(raw_result_port_a_busy))
    else $error("raw data changed without read");
  chk_avg_data_cause: assert property ($changed(averaged_result_port_a_data) |-> $past(averaged_result_read_enable) || $past(averaged_result_port_a_busy))
    else $error("averaged data changed without read");
  cover property (raw_result_read_enable && raw_result_port_a_busy);
  cover property ($rose(averaged_result_write_busy));
  cover property (averaged_init_config_read && threshold_evaluator_read);
endmodule : result_read_sva

bind adc_result_ram_user_read result_read_sva chk (.*);

// File: result_reader.sv
// user fabric model reading one result memory through port a
// assumes the block samples on the rising edge; this model drives on falling edges
module result_reader
  import adc_result_ram_pkg::*;
(
  // command from the bench
  input wire logic clock, start,
  input wire logic [averaged_memory_address_width-1:0] target,
  // port a of one result memory
  input wire logic busy,
  input wire logic [result_memory_data_width-1:0] data_in,
  output logic read_enable, done,
  output logic [averaged_memory_address_width-1:0] read_address,
  output logic [result_memory_data_width-1:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {read_enable, done, read_address, word} = '0;
  end
  always begin
    @(negedge clock iff start);
    while (busy) @(negedge clock);
    read_enable = 1'b1;
    read_address = target;
    @(negedge clock);
    read_enable = 1'b0;
    read_address = ~target;
    word = data_in;
    done = 1'b1;
    @(negedge clock);
    done = 1'b0;
  end
endmodule : result_reader

// File: test_adc_result_ram_user_read.sv
// bench for the result memory read-out block: writes, user reads, port-a sharing
// assumes result_reader as the user fabric on both read paths
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_adc_result_ram_user_read
  import adc_result_ram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, sample_sequencer_valid, averaging_evaluator_valid, raw_start, avg_start, raw_done, avg_done;
  logic raw_init_config_read, raw_evaluator_read, averaged_init_config_read, threshold_evaluator_read;
  logic raw_result_read_enable, averaged_result_read_enable, raw_result_port_a_busy, averaged_result_port_a_busy;
  logic raw_result_write_busy, averaged_result_write_busy;
  logic [7:0] sample_sequencer_slot, averaging_evaluator_channel;
  logic [11:0] sample_sequencer_result, averaging_evaluator_result;
  logic [8:0] raw_init_config_address, raw_evaluator_address, averaged_init_config_address, raw_target;
  logic [8:0] threshold_evaluator_address, raw_result_read_address, averaged_result_read_address, avg_target;
  logic [8:0] raw_result_port_a_data, averaged_result_port_a_data, raw_word, avg_word;
  int failures, check_count;
  adc_result_ram_user_read DUT (.*);
  result_reader raw_user (.clock(clock), .start(raw_start), .target(raw_target), .busy(raw_result_port_a_busy),
    .data_in(raw_result_port_a_data), .read_enable(raw_result_read_enable), .done(raw_done),
    .read_address(raw_result_read_address), .word(raw_word));
  result_reader avg_user (.clock(clock), .start(avg_start), .target(avg_target), .busy(averaged_result_port_a_busy),
    .data_in(averaged_result_port_a_data), .read_enable(averaged_result_read_enable), .done(avg_done),
    .read_address(averaged_result_read_address), .word(avg_word));
  always #10 clock = ~clock;
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input bit sel, input logic [7:0] idx, input logic [11:0] v);
    @(negedge clock);
    if (sel) {averaging_evaluator_valid, averaging_evaluator_channel, averaging_evaluator_result} = {1'b1, idx, v};
    else {sample_sequencer_valid, sample_sequencer_slot, sample_sequencer_result} = {1'b1, idx, v};
    @(negedge clock);
    {sample_sequencer_valid, averaging_evaluator_valid} = 2'h0;
    repeat (2) begin
      `CHK("write_busy", 1'b1, sel ? averaged_result_write_busy : raw_result_write_busy)
      @(negedge clock);
    end
    `CHK("write_busy", 1'b0, sel ? averaged_result_write_busy : raw_result_write_busy)
  endtask : wr
  task automatic rd(input bit sel, input logic [8:0] a, input logic [8:0] e);
    int n = 0;
    @(negedge clock);
    if (sel) {avg_start, avg_target} <= {1'b1, a};
    else {raw_start, raw_target} <= {1'b1, a};
    do begin
      @(posedge clock);
      n++;
    end while (!(sel ? avg_done : raw_done) && n < 50);
    `CHK("read_done", 1'b1, sel ? avg_done : raw_done)
    @(negedge clock);
    {raw_start, avg_start} <= 2'h0;
    `CHK("read_word", e, sel ? avg_word : raw_word)
  endtask : rd
  task automatic rd2(input bit sel, input logic [7:0] idx, input logic [11:0] v);
    rd(sel, {idx, 1'b0}, v[8:0]);
    rd(sel, {idx, 1'b1}, {6'h00, v[11:9]});
  endtask : rd2
  task automatic t_store(input bit sel);
    wr(sel, 8'h00, 12'hfff);
    wr(sel, 8'hff, 12'h801);
    wr(sel, 8'h09, 12'h5a3);
    wr(sel, 8'h09, 12'h2b6);
    wr(sel, 8'h0a, 12'h1c4);
    rd2(sel, 8'h00, 12'hfff);
    rd2(sel, 8'hff, 12'h801);
    rd2(sel, 8'h09, 12'h2b6);
    rd2(sel, 8'h0a, 12'h1c4);
  endtask : t_store
  task automatic t_refuse();
    @(negedge clock);
    {sample_sequencer_valid, sample_sequencer_slot, sample_sequencer_result} = {1'b1, 8'h20, 12'h3c5};
    @(negedge clock);
    sample_sequencer_result = 12'hc3a;
    repeat (2) @(negedge clock);
    sample_sequencer_valid = 1'b0;
    `CHK("write_busy", 1'b0, raw_result_write_busy)
    rd2(1'b0, 8'h20, 12'h3c5);
  endtask : t_refuse
  task automatic t_share(input bit sel);
    @(negedge clock);
    if (sel) {averaged_init_config_read, averaged_init_config_address} = {1'b1, 9'h012};
    else {raw_init_config_read, raw_init_config_address} = {1'b1, 9'h012};
    {raw_evaluator_read, raw_evaluator_address, threshold_evaluator_read, threshold_evaluator_address} = {!sel, 9'h013, sel, 9'h013};
    fork
      rd(sel, 9'h014, 9'h1c4);
      begin
        @(negedge clock);
        `CHK("port_a_busy", 1'b1, sel ? averaged_result_port_a_busy : raw_result_port_a_busy)
        @(negedge clock);
        {raw_init_config_read, raw_evaluator_read, averaged_init_config_read, threshold_evaluator_read} = 4'h0;
        @(negedge clock);
        `CHK("internal_word", 9'h0b6, sel ? averaged_result_port_a_data : raw_result_port_a_data)
      end
    join
  endtask : t_share
  // evaluator alone takes port a: its own address is read
  task automatic t_engine(input bit sel);
    @(negedge clock);
    if (sel) {threshold_evaluator_read, threshold_evaluator_address} = {1'b1, 9'h013};
    else {raw_evaluator_read, raw_evaluator_address} = {1'b1, 9'h013};
    @(negedge clock);
    `CHK("port_a_busy", 1'b1, sel ? averaged_result_port_a_busy : raw_result_port_a_busy)
    {raw_evaluator_read, threshold_evaluator_read} = 2'h0;
    @(negedge clock);
    `CHK("engine_word", 9'h001, sel ? averaged_result_port_a_data : raw_result_port_a_data)
    `CHK("port_a_free", 1'b0, sel ? averaged_result_port_a_busy : raw_result_port_a_busy)
  endtask : t_engine
  initial begin
    {clock, rst_n, sample_sequencer_valid, averaging_evaluator_valid, raw_start, avg_start} = '0;
    {raw_init_config_read, raw_evaluator_read, averaged_init_config_read, threshold_evaluator_read} = '0;
    {sample_sequencer_slot, averaging_evaluator_channel, sample_sequencer_result, averaging_evaluator_result} = '0;
    {raw_init_config_address, raw_evaluator_address, averaged_init_config_address, raw_target} = '0;
    {threshold_evaluator_address, avg_target} = '0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    `CHK("idle_status", 4'h0, {raw_result_port_a_busy, raw_result_write_busy, averaged_result_port_a_busy, averaged_result_write_busy})
    `CHK("reset_data", {2{read_data_reset_value}}, {raw_result_port_a_data, averaged_result_port_a_data})
    t_store(1'b0);
    t_store(1'b1);
    t_refuse();
    t_share(1'b0);
    t_share(1'b1);
    t_engine(1'b0);
    t_engine(1'b1);
    end_sim();
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule : test_adc_result_ram_user_read
